// *** bench/lrd_host_model.sv ***
// behavioural serial bus host that reads the light readout
`timescale 1ns/1ps
module lrd_host_model (
   input wire logic sys_clk,
   input wire logic sda,
   output logic scl,
   output logic sdaLow
);
   // clock stands high and data is released outside frames
   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end

   // a quarter of the 64 ns link clock period
   task automatic quarter();
      repeat (4) @(negedge sys_clk);
   endtask : quarter

   task automatic start_cond();
      sdaLow = 1'b1;
      quarter();
      scl = 1'b0;
      quarter();
   endtask : start_cond

   task automatic stop_cond();
      sdaLow = 1'b1;
      quarter();
      scl = 1'b1;
      quarter();
      sdaLow = 1'b0;
      quarter();
   endtask : stop_cond

   // nine bits; data set while clock is low, line sampled mid high phase
   task automatic xfer(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx,
                       output logic ackOut);
      logic [8:0] bits;
      bits = {tx, ackIn};
      for (int i = 8; i >= 0; i--) begin
         sdaLow = !bits[i];
         quarter();
         scl = 1'b1;
         quarter();
         bits[i] = sda;
         quarter();
         scl = 1'b0;
         quarter();
      end
      {rx, ackOut} = bits;
   endtask : xfer
endmodule : lrd_host_model

// *** bench/lrd_light_readout_checker.sv ***
// port assertions for the dual channel light readout
`timescale 1ns/1ps
module lrd_light_readout_checker #(
   parameter int INT_CYCLES = 200
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic bbPulse,
   input wire logic irPulse,
   input wire logic powerDown,
   input wire logic smbusVariant,
   input wire lrd_pkg::lrd_window_t windowIn,
   input wire logic windowLoad,
   input wire logic intClear,
   input wire logic addrPinLow,
   input wire logic addrPinHigh,
   input wire logic sclIn,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic intOut,
   input wire logic intOe,
   input wire lrd_pkg::lrd_result_t resultOut
);
   import lrd_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // pins only ever pull low
   property p_open_drain; intOut == 1'b0 && sdaOut == 1'b0; endproperty
   a_open_drain: assert property (p_open_drain) else $error("pin driven high");
   // outputs still at rest on the first edge after release
   property p_reset_out; $rose(rst_n) |-> !intOe && !sdaOe && resultOut == '0; endproperty
   a_reset_out: assert property (p_reset_out) else $error("output not at rest");
   // data line moves only while the link clock is low, else it forms start or stop
   property p_sda_low_phase; $changed(sdaOe) |-> !sclIn; endproperty
   a_sda_low_phase: assert property (p_sda_low_phase) else $error("sda moved, scl high");
   // a new result stands for a while before the next transfer
   property p_result_hold; $changed(resultOut) |=> $stable(resultOut)[*8]; endproperty
   a_result_hold: assert property (p_result_hold) else $error("result changed twice");
   // level interrupt stays until cleared
   property p_level_sticky;
      intOe && !smbusVariant && !$past(smbusVariant) && !intClear && !$past(intClear) |=> intOe;
   endproperty
   a_level_sticky: assert property (p_level_sticky) else $error("level int dropped");
   // a held clear with no conversions running releases the line
   property p_level_clear; (powerDown && intClear && !smbusVariant)[*4] |=> !intOe; endproperty
   a_level_clear: assert property (p_level_clear) else $error("clear ignored");
   // alert style ignores the clear input while the bus is idle
   property p_alert_sticky; (smbusVariant && sclIn)[*5] ##0 intOe |=> intOe; endproperty
   a_alert_sticky: assert property (p_alert_sticky) else $error("alert int dropped");
   // no conversion, hence no new interrupt, in power down
   property p_pd_quiet; powerDown[*4] |=> !$rose(intOe); endproperty
   a_pd_quiet: assert property (p_pd_quiet) else $error("int rose in power down");

   c_int: cover property ($rose(intOe));
   c_ack: cover property ($rose(sdaOe));
   c_res: cover property ($changed(resultOut));
endmodule : lrd_light_readout_checker

bind lrd_light_readout lrd_light_readout_checker #(.INT_CYCLES(INT_CYCLES)) chk_inst (
   .sys_clk, .rst_n, .bbPulse, .irPulse, .powerDown, .smbusVariant, .windowIn, .windowLoad,
   .intClear, .addrPinLow, .addrPinHigh, .sclIn, .sdaIn, .sdaOut, .sdaOe, .intOut, .intOe,
   .resultOut
);

// *** bench/tb_top.sv ***
// self-checking bench for the dual channel light readout
`timescale 1ns/1ps
module tb_top;
   import lrd_pkg::*;
   localparam int NCYC = 200;
   localparam logic [31:0] RES_EXP = {16'(NCYC / 20), 16'(NCYC / 8)};
   localparam logic [6:0] ADDRS [3] = '{ADDR_LOW, ADDR_FLOAT, ADDR_HIGH};
   // clock starts low without an event, so no false falling edge at time zero
   logic clk = 1'b0;
   logic rstN, bbPulse, irPulse, powerDown, smbusVariant, windowLoad, intClear;
   logic addrPinLow, addrPinHigh, scl, sdaLow, sda, sdaOut, sdaOe, intOut, intOe, ack;
   logic ackData;
   lrd_window_t windowIn;
   lrd_result_t result;
   logic [31:0] data;
   int errors, checkCount, pulseCnt, n;

   // pull-up on the data line, either party may pull it low
   assign sda = !(sdaLow || sdaOe);

   lrd_light_readout #(.INT_CYCLES(NCYC)) lrd_light_readout_inst (
      .sys_clk(clk), .rst_n(rstN), .bbPulse(bbPulse), .irPulse(irPulse),
      .powerDown(powerDown), .smbusVariant(smbusVariant), .windowIn(windowIn),
      .windowLoad(windowLoad), .intClear(intClear), .addrPinLow(addrPinLow),
      .addrPinHigh(addrPinHigh), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .intOut(intOut), .intOe(intOe), .resultOut(result)
   );
   lrd_host_model lrd_host_model_inst (.sys_clk(clk), .sda(sda), .scl(scl), .sdaLow(sdaLow));

   always #2 clk = ~clk;
   // pulse periods divide the window, so every window holds the same counts
   always @(negedge clk) begin
      pulseCnt <= pulseCnt + 1;
      bbPulse <= (pulseCnt % 8) < 4;
      irPulse <= (pulseCnt % 20) < 10;
   end

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      checkCount++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t ns %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check_val

   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask : cyc

   task automatic load_window(input logic [15:0] up, input logic [15:0] lo, input logic [3:0] p);
      windowIn = {up, lo, p};
      windowLoad = 1'b1;
      cyc(1);
      windowLoad = 1'b0;
   endtask : load_window

   // one read frame; the host refuses the last byte to end it
   task automatic bus_read(input logic [6:0] addr, input int cnt);
      logic [7:0] b;
      logic a;
      data = '0;
      lrd_host_model_inst.start_cond();
      lrd_host_model_inst.xfer({addr, 1'b1}, 1'b1, b, ack);
      for (int i = 0; i < cnt; i++) begin
         lrd_host_model_inst.xfer(8'hff, 1'(i == cnt - 1), b, a);
         data[8*i +: 8] = b;
      end
      lrd_host_model_inst.stop_cond();
   endtask : bus_read

   // one single byte write frame; the device acknowledges and drops it
   task automatic bus_write(input logic [6:0] addr, input logic [7:0] val);
      logic [7:0] b;
      lrd_host_model_inst.start_cond();
      lrd_host_model_inst.xfer({addr, 1'b0}, 1'b1, b, ack);
      lrd_host_model_inst.xfer(val, 1'b1, b, ackData);
      lrd_host_model_inst.stop_cond();
   endtask : bus_write

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checkCount, errors);
      if (errors == 0 && checkCount > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict

   // main sequence
   initial begin
      {rstN, powerDown, smbusVariant, windowLoad, intClear, addrPinLow, addrPinHigh} = '0;
      windowIn = '0;
      cyc(10);
      rstN = 1'b1;
      cyc(1);
      check_val(result, '0, "reset result");
      check_val(32'({intOe, sdaOe}), '0, "reset pins");
      cyc(450);
      check_val(result, RES_EXP, "both channels");
      $display("test conversion done");
      // every select level answers at its own address only
      for (int k = 0; k < 3; k++) begin
         addrPinLow = 1'(k == 0);
         addrPinHigh = 1'(k == 2);
         cyc(4);
         bus_read(ADDRS[k], 4);
         check_val(32'(ack), '0, "own address ack");
         check_val(data, RES_EXP, "read bytes");
         bus_read(7'h55, 0);
         check_val(32'(ack), 32'h1, "foreign address");
      end
      bus_write(ADDRS[2], 8'ha5);
      check_val(32'({ack, ackData}), '0, "write acked");
      $display("test address done");
      load_window(16'd20, 16'd0, 4'd3);
      n = 0;
      while (intOe !== 1'b1 && n < 700) begin
         cyc(1);
         n++;
      end
      check_val(32'(n > 400 && n <= 610), 32'h1, "persistence delay");
      load_window(16'hffff, 16'h0, 4'd0);
      cyc(450);
      check_val(32'(intOe), 32'h1, "level held");
      intClear = 1'b1;
      cyc(1);
      intClear = 1'b0;
      cyc(3);
      check_val(32'(intOe), '0, "level cleared");
      $display("test level interrupt done");
      smbusVariant = 1'b1;
      load_window(16'd20, 16'd0, 4'd0);
      cyc(210);
      load_window(16'hffff, 16'h0, 4'd0);
      intClear = 1'b1;
      cyc(1);
      intClear = 1'b0;
      cyc(3);
      check_val(32'(intOe), 32'h1, "clear input ignored");
      bus_read(ALERT_RESP_ADDR, 1);
      check_val(data, {24'h0, ADDR_HIGH, 1'b0}, "alert answer");
      check_val(32'(ack), '0, "alert address ack");
      cyc(3);
      check_val(32'(intOe), '0, "alert cleared");
      $display("test alert done");
      smbusVariant = 1'b0;
      powerDown = 1'b1;
      load_window(16'hffff, 16'd30, 4'd0);
      intClear = 1'b1;
      cyc(605);
      intClear = 1'b0;
      check_val(32'(intOe), '0, "quiet in power down");
      powerDown = 1'b0;
      cyc(210);
      check_val(32'(intOe), 32'h1, "below lower limit");
      $display("test power down done");
      print_verdict();
   end

   // watchdog: the sequence needs about 6000 cycles
   initial begin
      #200000;
      errors++;
      $display("[FAIL] %0t ns watchdog expired", $time);
      print_verdict();
   end
endmodule : tb_top

// *** rtl/lrd_channel_integrator.sv ***
// one channel's saturating photo pulse counter
`timescale 1ns/1ps
module lrd_channel_integrator (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic restart,
   input wire logic pulseTick,
   output logic [lrd_pkg::DATA_W-1:0] count
);
   import lrd_pkg::*;

   wire logic atMax = &count;
   always_ff @(posedge sys_clk) begin
      if (!rst_n || restart) begin
         count <= '0;
      end else if (pulseTick && !atMax) begin
         count <= count + 1'b1;
      end
   end
endmodule : lrd_channel_integrator

// *** rtl/lrd_light_readout.sv ***
// dual channel integrating light readout with serial read port and threshold interrupt
`timescale 1ns/1ps
module lrd_light_readout #(
   parameter int INT_CYCLES = lrd_pkg::INT_CYCLES_DEF
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic bbPulse,
   input wire logic irPulse,
   input wire logic powerDown,
   input wire logic smbusVariant,
   input wire lrd_pkg::lrd_window_t windowIn,
   input wire logic windowLoad,
   input wire logic intClear,
   input wire logic addrPinLow,
   input wire logic addrPinHigh,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   output logic intOut,
   output logic intOe,
   output lrd_pkg::lrd_result_t resultOut
);
   import lrd_pkg::*;

   logic [S_W-1:0] syncA;
   logic [S_W-1:0] syncB;
   logic [S_W-1:0] syncC;
   logic [TIMER_W-1:0] timer;
   logic [DATA_W-1:0] bbCount;
   logic [DATA_W-1:0] irCount;
   lrd_result_t pending;
   logic pendValid;
   lrd_window_t window;
   logic [PERSIST_W-1:0] persistCnt;
   logic intActive;
   lrd_bus_state_t state;
   logic [2:0] bitCnt;
   logic [7:0] rxShift;
   logic [7:0] txShift;
   logic [1:0] byteIdx;
   logic isRead;
   logic isAlert;
   logic hostAck;
   localparam logic [S_W-1:0] SYNC_IDLE = (S_W'(1) << S_SCL) | (S_W'(1) << S_SDA);
   // bus, pulse and select pins pass two flops; 4 ns sampling far outruns 400 kHz
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         syncA <= SYNC_IDLE; // bus lines rest high, so no false edge after reset
         syncB <= SYNC_IDLE;
         syncC <= SYNC_IDLE;
      end else begin
         syncA <= {addrPinHigh, addrPinLow, irPulse, bbPulse, sdaIn, sclIn};
         syncB <= syncA;
         syncC <= syncB;
      end
   end

   // edge detection on the settled copies only
   wire logic sclRise = syncB[S_SCL] & ~syncC[S_SCL];
   wire logic sclFall = ~syncB[S_SCL] & syncC[S_SCL];
   wire logic sdaBit = syncB[S_SDA];
   wire logic startCond = syncB[S_SCL] & syncC[S_SCL] & ~syncB[S_SDA] & syncC[S_SDA];
   wire logic stopCond = syncB[S_SCL] & syncC[S_SCL] & syncB[S_SDA] & ~syncC[S_SDA];
   wire logic bbTick = syncB[S_BB] & ~syncC[S_BB];
   wire logic irTick = syncB[S_IR] & ~syncC[S_IR];

   // low pin, high pin, or neither driven means floating
   wire logic [6:0] ownAddr = syncB[S_ALO] ? ADDR_LOW :
                              syncB[S_AHI] ? ADDR_HIGH : ADDR_FLOAT;

   // conversion timer; power down clears it and the counters
   wire logic convDone = !powerDown && (timer == TIMER_W'(INT_CYCLES - 1));
   always_ff @(posedge sys_clk) begin
      if (!rst_n || powerDown || convDone) begin
         timer <= '0;
      end else begin
         timer <= timer + 1'b1;
      end
   end

   // both integrators share restart and timer
   // restart on the cycle of transfer
   wire logic restartInt = powerDown || convDone;
   lrd_channel_integrator bbIntegrator (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .restart(restartInt),
      .pulseTick(bbTick),
      .count(bbCount)
   );
   lrd_channel_integrator irIntegrator (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .restart(restartInt),
      .pulseTick(irTick),
      .count(irCount)
   );
   // frame in progress: bus activity holds the data registers from start until stop, an address miss or a refused read byte
   wire logic hostBusy = (state != BUS_IDLE);

   // broadband into channel zero, infrared into channel one
   // pending stage is the second buffer
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pending <= '0;
         pendValid <= 1'b0;
      end else if (convDone) begin
         pending <= '{infrared: irCount, broadband: bbCount};
         pendValid <= 1'b1;
      end else if (!hostBusy) begin
         pendValid <= 1'b0;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         resultOut <= '0;
      end else if (pendValid && !hostBusy) begin
         resultOut <= pending;
      end
   end

   // host held window and persistence settings
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         window <= '{upper: '1, lower: '0, persist: '0};
      end else if (windowLoad) begin
         window <= windowIn;
      end
   end

   // window test on each fresh broadband result
   wire logic outside = (bbCount > window.upper) || (bbCount < window.lower);
   wire logic [PERSIST_W-1:0] nextPersist = (&persistCnt) ? persistCnt : persistCnt + 1'b1;
   // fire once the run of outside results reaches the setting
   wire logic fire = convDone && outside && (nextPersist >= window.persist);
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         persistCnt <= '0;
      end else if (convDone) begin
         persistCnt <= outside ? nextPersist : '0;
      end
   end

   // alert answered when the response byte finishes on the bus
   wire logic alertServed = isAlert && (state == BUS_TX_DONE) && sclFall;
   // level variant clears only on host clear
   // alert variant clears on the alert response read
   wire logic clearReq = smbusVariant ? alertServed : intClear;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         intActive <= 1'b0;
      end else if (fire) begin
         intActive <= 1'b1; // a new event beats a clear in the same cycle
      end else if (clearReq) begin
         intActive <= 1'b0;
      end
   end

   // open drain: pin value fixed low, enable pulls it
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         intOut <= 1'b0;
         intOe <= 1'b0;
         sdaOut <= 1'b0;
      end else begin
         intOut <= 1'b0;
         intOe <= intActive;
         sdaOut <= 1'b0;
      end
   end
   // transmit byte selection: four data bytes low first, then fill
   function automatic logic [7:0] byte_sel(input lrd_result_t r, input logic [1:0] idx);
      byte_sel = r[{idx, 3'h0} +: 8];
   endfunction : byte_sel
   wire logic [7:0] dataByteNext = byte_sel(resultOut, byteIdx + 2'h1);
   wire logic lastSent = isAlert || (byteIdx == LAST_BYTE);
   wire logic [7:0] firstByte = isAlert ? {ownAddr, 1'b0} : byte_sel(resultOut, byteIdx);
   wire logic addrMatch = (rxShift[7:1] == ownAddr);
   wire logic alertMatch = smbusVariant && intActive && rxShift[0] &&
                           (rxShift[7:1] == ALERT_RESP_ADDR);

   // serial slave, data changes on falling clock, sampled on rising
   always_ff @(posedge sys_clk) begin
      if (!rst_n || stopCond) begin
         state <= BUS_IDLE;
         sdaOe <= 1'b0;
         bitCnt <= '0;
         rxShift <= '0;
         txShift <= '0;
         byteIdx <= '0;
         isRead <= 1'b0;
         isAlert <= 1'b0;
         hostAck <= 1'b0;
      end else if (startCond) begin
         state <= BUS_ADDR;
         sdaOe <= 1'b0;
         bitCnt <= '0;
         byteIdx <= '0;
         isAlert <= 1'b0;
      end else begin
         case (state)
            BUS_ADDR, BUS_RX: begin
               if (sclRise) begin
                  rxShift <= {rxShift[6:0], sdaBit};
                  bitCnt <= bitCnt + 1'b1;
                  if (bitCnt == LAST_BIT) begin
                     state <= (state == BUS_ADDR) ? BUS_ADDR_DONE : BUS_RX_DONE;
                  end
               end
            end
            BUS_ADDR_DONE: begin
               if (sclFall) begin
                  isRead <= rxShift[0];
                  isAlert <= alertMatch;
                  if (addrMatch || alertMatch) begin
                     sdaOe <= 1'b1;
                     state <= BUS_ADDR_ACK;
                  end else begin
                     state <= BUS_IDLE;
                  end
               end
            end
            BUS_ADDR_ACK: begin
               if (sclFall) begin
                  bitCnt <= '0;
                  if (isRead) begin
                     txShift <= firstByte;
                     sdaOe <= ~firstByte[7];
                     state <= BUS_TX;
                  end else begin
                     sdaOe <= 1'b0;
                     state <= BUS_RX;
                  end
               end
            end
            BUS_TX: begin
               if (sclRise) begin
                  bitCnt <= bitCnt + 1'b1;
                  if (bitCnt == LAST_BIT) begin
                     state <= BUS_TX_DONE;
                  end
               end else if (sclFall) begin
                  txShift <= {txShift[6:0], 1'b0};
                  sdaOe <= ~txShift[6];
               end
            end
            BUS_TX_DONE: begin
               if (sclFall) begin
                  sdaOe <= 1'b0;
                  state <= BUS_MACK;
               end
            end
            BUS_MACK: begin
               if (sclRise) begin
                  hostAck <= ~sdaBit;
                  state <= BUS_MACK_DONE;
               end
            end
            BUS_MACK_DONE: begin
               if (sclFall) begin
                  bitCnt <= '0;
                  if (hostAck) begin
                     txShift <= lastSent ? FILL_BYTE : dataByteNext; // fill past last byte
                     sdaOe <= lastSent ? 1'b0 : ~dataByteNext[7];
                     byteIdx <= lastSent ? byteIdx : byteIdx + 1'b1;
                     isAlert <= 1'b0;
                     state <= BUS_TX;
                  end else begin
                     state <= BUS_IDLE;
                  end
               end
            end
            BUS_RX_DONE: begin
               if (sclFall) begin
                  sdaOe <= 1'b1; // writes are acknowledged and discarded
                  state <= BUS_RX_ACK;
               end
            end
            BUS_RX_ACK: begin
               if (sclFall) begin
                  sdaOe <= 1'b0;
                  bitCnt <= '0;
                  state <= BUS_RX;
               end
            end
            default: begin
               sdaOe <= 1'b0;
               state <= BUS_IDLE;
            end
         endcase
      end
   end
endmodule : lrd_light_readout

// *** rtl/lrd_pkg.sv ***
// shared constants, types and states for the dual channel light readout
// How it works
// - both channel integrators run on one timer
// - broadband to channel zero, infrared to one
// - results buffered, host never sees mixed bytes
// - next integration restarts right after transfer
// - results are unsigned 16 bit, read serially
// - broadband result outside upper or lower limit interrupts
// - interrupt only after persistence count is reached
// - serial alert variant answers alert response read
// - level variant holds interrupt until host clears
// - interrupt pin is open drain, pulls low
// - three level select pin picks bus address
// - bus up to 400 kHz, oversampled here
// - power down stops all conversion activity
package lrd_pkg;
   localparam int CLK_MHZ = 250;
   // integration time in microseconds, a plain default
   localparam int INT_TIME_US = 100;
   localparam int INT_CYCLES_DEF = INT_TIME_US * CLK_MHZ;
   localparam int TIMER_W = 24;
   localparam int DATA_W = 16;
   localparam int PERSIST_W = 4;
   // bus addresses per select level, values are arbitrary
   localparam logic [6:0] ADDR_LOW = 7'h10;
   localparam logic [6:0] ADDR_FLOAT = 7'h11;
   localparam logic [6:0] ADDR_HIGH = 7'h12;
   localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;
   localparam logic [7:0] FILL_BYTE = 8'hff;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [1:0] LAST_BYTE = 2'h3;
   // synchroniser vector lanes
   localparam int S_SCL = 0;
   localparam int S_SDA = 1;
   localparam int S_BB = 2;
   localparam int S_IR = 3;
   localparam int S_ALO = 4;
   localparam int S_AHI = 5;
   localparam int S_W = 6;

   typedef struct packed {
      logic [DATA_W-1:0] infrared;
      logic [DATA_W-1:0] broadband;
   } lrd_result_t;

   typedef struct packed {
      logic [DATA_W-1:0] upper;
      logic [DATA_W-1:0] lower;
      logic [PERSIST_W-1:0] persist;
   } lrd_window_t;

   typedef enum logic [3:0] {
      BUS_IDLE, BUS_ADDR, BUS_ADDR_DONE, BUS_ADDR_ACK, BUS_TX, BUS_TX_DONE,
      BUS_MACK, BUS_MACK_DONE, BUS_RX, BUS_RX_DONE, BUS_RX_ACK
   } lrd_bus_state_t;
endpackage : lrd_pkg
